// ==== itd_core.sv ====
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module itd_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic        waitrequest,
  // status
  output logic        busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_RUN} itd_st_type;

  typedef struct packed {
    itd_st_type  st;
    logic        wr_ack;
    logic [31:0] rdata;
    logic [13:0] instr;
    logic [4:0]  ctrl;
    logic [7:0]  mask;
    logic [7:0]  acc;
    logic [6:0]  fsel;
    logic [6:0]  ptr0;
    logic [6:0]  ptr1;
    logic [1:0]  cyc_left;
    logic [1:0]  cyc_tot;
    logic [7:0]  rd_val;
    logic        rd_done;
    logic        ind_extra;
    logic        waitreq;
    logic        busy;
  } itd_state_type;

  itd_state_type s_r, s_nxt;
  logic [7:0] file_mem [0:127];

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  logic [1:0] phase;
  logic       icyc_end;
  logic [1:0] cls;
  logic       dest;
  logic [6:0] faddr;
  logic [2:0] bidx;
  logic       ptr_n;
  logic [1:0] mode;
  logic [7:0] lit;

  itd_phase u_phase (
    .clk      (clk),
    .rst      (rst),
    .phase    (phase),
    .icyc_end (icyc_end)
  );

  itd_fields u_fields (
    .word  (s_r.instr),
    .cls   (cls),
    .dest  (dest),
    .faddr (faddr),
    .bidx  (bidx),
    .ptr_n (ptr_n),
    .mode  (mode),
    .lit   (lit)
  );

  // ----------------------------------------
  // operand addressing
  // ----------------------------------------
  logic       ptr_op;
  logic       ind_f;
  logic       use_n;
  logic [6:0] ptr_val;
  logic [6:0] ptr_upd;
  logic [6:0] eaddr;
  logic       prog_ind;
  logic       names_file;

  always_comb begin
    ptr_op     = s_r.ctrl[itd_pkg::C_PTROP] && cls == 2'h2;
    names_file = cls != 2'h2;
    ind_f      = names_file &&
                 (faddr == itd_pkg::IND0_ADDR ||
                  faddr == itd_pkg::IND1_ADDR);
    use_n      = ptr_op ? ptr_n : faddr[0];
    ptr_val    = use_n ? s_r.ptr1 : s_r.ptr0;
    case (itd_pkg::itd_mode_type'(mode))
      itd_pkg::UPD_PRE_INC, itd_pkg::UPD_POST_INC: ptr_upd = ptr_val + 7'h01;
      itd_pkg::UPD_PRE_DEC, itd_pkg::UPD_POST_DEC: ptr_upd = ptr_val - 7'h01;
      default: ptr_upd = ptr_val;
    endcase
    if (ptr_op) begin
      eaddr = mode[1] ? ptr_val : ptr_upd;
    end else if (ind_f) begin
      eaddr = ptr_val;
    end else begin
      eaddr = faddr;
    end
    prog_ind = (ptr_op || ind_f) &&
               (use_n ? s_r.ctrl[itd_pkg::C_PROG1]
                      : s_r.ctrl[itd_pkg::C_PROG0]);
  end

  // ----------------------------------------
  // modify step and write-back target
  // ----------------------------------------
  logic [7:0] result;
  logic       last_cyc;
  logic       mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic       host_we;

  always_comb begin
    if (cls == itd_pkg::CLS_BIT) begin
      result = s_r.rd_val ^ (8'h01 << bidx);
    end else begin
      result = s_r.rd_val ^ s_r.mask;
    end
    last_cyc = s_r.st == ST_RUN && icyc_end && s_r.cyc_left == 2'h1;
    host_we  = write && s_r.wr_ack && address == itd_pkg::A_FDATA &&
               s_r.st == ST_IDLE;
    // bit ops always land in the file; byte ops follow d
    mem_we = (last_cyc && names_file &&
              (cls == itd_pkg::CLS_BIT || dest)) || host_we;
    mem_wa = s_r.fsel;
    mem_wd = host_we ? writedata[7:0] : result;
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic       req;
  logic [31:0] rd_mux;

  always_comb begin
    s_nxt = s_r;
    req   = (read || write) && !s_r.wr_ack;
    case (address)
      itd_pkg::A_INSTR:  rd_mux = {18'h0, s_r.instr};
      itd_pkg::A_CTRL:   rd_mux = {27'h0, s_r.ctrl};
      itd_pkg::A_MASK:   rd_mux = {24'h0, s_r.mask};
      itd_pkg::A_STATUS: rd_mux = {26'h0, s_r.ind_extra, s_r.cyc_tot,
                                   cls, s_r.st != ST_IDLE};
      itd_pkg::A_FIELDS: rd_mux = {18'h0, mode, ptr_n, bidx,
                                   dest, faddr};
      itd_pkg::A_ACC:    rd_mux = {24'h0, s_r.acc};
      itd_pkg::A_FADDR:  rd_mux = {25'h0, s_r.fsel};
      itd_pkg::A_FDATA:  rd_mux = {24'h0, file_mem[s_r.fsel]};
      itd_pkg::A_PTRS:   rd_mux = {17'h0, s_r.ptr1, 1'b0, s_r.ptr0};
      default:           rd_mux = 32'h0;
    endcase
    // one wait state: answer on the edge after the request
    s_nxt.wr_ack  = req;
    s_nxt.waitreq = !req;
    if (req && read) begin
      s_nxt.rdata = rd_mux;
    end
    case (s_r.st)
      ST_IDLE: begin
        // writes land at the edge that completes the access
        if (write && s_r.wr_ack) begin
          case (address)
            itd_pkg::A_INSTR: begin
              s_nxt.instr = writedata[itd_pkg::IW-1:0];
              s_nxt.st    = ST_ALIGN;
            end
            itd_pkg::A_CTRL:  s_nxt.ctrl = writedata[4:0];
            itd_pkg::A_MASK:  s_nxt.mask = writedata[7:0];
            itd_pkg::A_ACC:   s_nxt.acc  = writedata[7:0];
            itd_pkg::A_FADDR: s_nxt.fsel = writedata[6:0];
            itd_pkg::A_PTRS: begin
              s_nxt.ptr0 = writedata[6:0];
              s_nxt.ptr1 = writedata[14:8];
            end
            default: ;
          endcase
        end
      end
      ST_ALIGN: begin
        // start on an instruction-cycle boundary
        if (icyc_end) begin
          s_nxt.st        = ST_RUN;
          s_nxt.cyc_tot   = itd_pkg::icycles(
                              s_r.ctrl[itd_pkg::C_FLOW +: 2],
                              prog_ind);
          s_nxt.cyc_left  = s_nxt.cyc_tot;
          s_nxt.ind_extra = prog_ind;
          s_nxt.fsel      = eaddr;
          s_nxt.rd_done   = 1'b0;
        end
      end
      ST_RUN: begin
        // read even when the instruction only writes
        if (phase == itd_pkg::PH_READ && !s_r.rd_done) begin
          s_nxt.rd_val  = file_mem[s_r.fsel];
          s_nxt.rd_done = 1'b1;
        end
        if (icyc_end) begin
          s_nxt.cyc_left = s_r.cyc_left - 2'h1;
          if (s_r.cyc_left == 2'h1) begin
            s_nxt.st = ST_IDLE;
            if (ptr_op) begin
              s_nxt.acc = s_r.rd_val;
            end else if (cls == 2'h2) begin
              s_nxt.acc = lit;
            end else if (cls == itd_pkg::CLS_BYTE && !dest) begin
              s_nxt.acc = result;
            end
            if (ptr_op && !use_n) begin
              s_nxt.ptr0 = ptr_upd;
            end
            if (ptr_op && use_n) begin
              s_nxt.ptr1 = ptr_upd;
            end
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    s_nxt.busy = s_nxt.st != ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.ctrl  <= itd_pkg::CTRL_RST;
      s_r.mask  <= itd_pkg::MASK_RST;
      s_r.instr <= itd_pkg::INSTR_RST;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata    = s_r.rdata;
  assign waitrequest = s_r.waitreq;
  assign busy        = s_r.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [3:0] run_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_cnt <= 4'h0;
    end else begin
      run_cnt <= (s_r.st == ST_RUN) ? run_cnt + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_run_len;
    last_cyc |-> run_cnt == {s_r.cyc_tot - 2'h1, 2'h3};
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("run length differs from four clocks per cycle");

  property p_read_first;
    last_cyc |-> s_r.rd_done;
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("write-back before operand read");

  property p_single;
    s_r.st == ST_RUN && !s_r.ind_extra &&
    s_r.ctrl[itd_pkg::C_FLOW +: 2] == 2'h0 |-> s_r.cyc_tot == 2'h1;
  endproperty
  a_single: assert property (p_single)
    else $error("plain instruction not one cycle");

  property p_call;
    s_r.st == ST_RUN && !s_r.ind_extra &&
    s_r.ctrl[itd_pkg::C_FLOW +: 2] == 2'h1 |-> s_r.cyc_tot == 2'h2;
  endproperty
  a_call: assert property (p_call)
    else $error("call not two cycles");

  property p_ret;
    s_r.st == ST_RUN && !s_r.ind_extra &&
    s_r.ctrl[itd_pkg::C_FLOW +: 2] == 2'h2 |-> s_r.cyc_tot == 2'h2;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return not two cycles");

  property p_branch;
    s_r.st == ST_RUN && !s_r.ind_extra &&
    s_r.ctrl[itd_pkg::C_FLOW +: 2] == 2'h3 |-> s_r.cyc_tot == 2'h2;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch not two cycles");

  property p_extra;
    s_r.st == ST_ALIGN && icyc_end && prog_ind |=>
    s_r.cyc_tot == itd_pkg::icycles(
      $past(s_r.ctrl[itd_pkg::C_FLOW +: 2]), 1'b0) + 2'h1;
  endproperty
  a_extra: assert property (p_extra)
    else $error("missing indirect extra cycle");

  property p_dest_acc;
    last_cyc && cls == itd_pkg::CLS_BYTE && !dest |-> !mem_we;
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("d=0 wrote the file");

  property p_one_bit;
    last_cyc && cls == itd_pkg::CLS_BIT |->
    mem_we && $countones(mem_wd ^ s_r.rd_val) == 1;
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("bit op changed other than one bit");

  property p_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not after one wait state");
endmodule
`default_nettype wire

// ==== itd_fields.sv ====
`timescale 1ns/1ps
`default_nettype none
module itd_fields (
  // word
  input  wire logic [13:0] word,
  // fields
  output logic [1:0] cls,
  output logic       dest,
  output logic [6:0] faddr,
  output logic [2:0] bidx,
  output logic       ptr_n,
  output logic [1:0] mode,
  output logic [7:0] lit
);
  // literal/control covers both codes with a high top bit
  assign cls   = word[itd_pkg::CLS_HI] ? 2'h2 :
                 word[itd_pkg::CLS_HI:itd_pkg::CLS_LO];
  assign dest  = word[itd_pkg::DEST_BIT];
  assign faddr = word[itd_pkg::F_W-1:0];
  assign bidx  = word[itd_pkg::B_HI:itd_pkg::B_LO];
  assign ptr_n = word[itd_pkg::PTR_BIT];
  assign mode  = word[itd_pkg::MODE_HI:0];
  // bits 11:8 of literal words never reach lit; bits 9:8 still show in bidx
  assign lit   = word[itd_pkg::K_W-1:0];
endmodule
`default_nettype wire

// ==== itd_phase.sv ====
`timescale 1ns/1ps
`default_nettype none
module itd_phase (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // phase
  output logic [1:0] phase,
  output logic       icyc_end
);
  logic [1:0] ph_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end

  assign phase    = ph_r;
  assign icyc_end = (ph_r == itd_pkg::PH_LAST);

  property p_period;
    @(posedge clk) disable iff (rst)
    icyc_end |-> ##4 icyc_end;
  endproperty
  a_period: assert property (p_period)
    else $error("instruction cycle is not four clocks");
endmodule
`default_nettype wire

// ==== itd_pkg.sv ====
`default_nettype none
package itd_pkg;

  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int IW       = 14;
  localparam int CLS_HI   = 13;
  localparam int CLS_LO   = 12;
  localparam int DEST_BIT = 7;
  localparam int F_W      = 7;
  localparam int B_HI     = 9;
  localparam int B_LO     = 7;
  localparam int PTR_BIT  = 2;
  localparam int MODE_HI  = 1;
  localparam int K_W      = 8;
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [6:0] IND0_ADDR = 7'h00;
  localparam logic [6:0] IND1_ADDR = 7'h01;
  localparam logic [6:0] FILE_MAX  = 7'h7F;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int OSC_PER_ICYC = 4;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_READ = 2'h1;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] A_INSTR  = 6'h00;
  localparam logic [5:0] A_CTRL   = 6'h04;
  localparam logic [5:0] A_MASK   = 6'h08;
  localparam logic [5:0] A_STATUS = 6'h0C;
  localparam logic [5:0] A_FIELDS = 6'h10;
  localparam logic [5:0] A_ACC    = 6'h14;
  localparam logic [5:0] A_FADDR  = 6'h18;
  localparam logic [5:0] A_FDATA  = 6'h1C;
  localparam logic [5:0] A_PTRS   = 6'h20;
  localparam int C_PROG0 = 0;
  localparam int C_PROG1 = 1;
  localparam int C_FLOW  = 2;
  localparam int C_PTROP = 4;
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [7:0]  MASK_RST = 8'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  typedef enum logic [1:0] {
    FLOW_SINGLE, FLOW_CALL, FLOW_RET, FLOW_BRANCH
  } itd_flow_type;

  typedef enum logic [1:0] {
    UPD_PRE_INC, UPD_PRE_DEC, UPD_POST_INC, UPD_POST_DEC
  } itd_mode_type;

  // instruction cycles for a flow kind plus indirect penalty
  function automatic logic [1:0] icycles(input logic [1:0] flow,
                                         input logic       prog_ind);
    logic [1:0] n;
    n = (flow == FLOW_SINGLE) ? 2'h1 : 2'h2;
    return n + {1'b0, prog_ind};
  endfunction

endpackage
`default_nettype wire

// ==== tb_itd_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_itd_core;
  // ------------------------------
  // signals
  // ------------------------------
  logic        clk;
  logic        rst;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        busy;
  logic [31:0] rd;
  int          error_cnt;
  int          comparisons;
  int          run_len;
  int          last_len;
  logic [2:0]  pw [5] = '{3'h2, 3'h0, 3'h3, 3'h1, 3'h4};
  logic [7:0]  pa [5] = '{8'hA0, 8'hA2, 8'hA2, 8'hA0, 8'hA1};
  logic [15:0] pp [5] = '{16'h0001, 16'h0002, 16'h0001, 16'h0000,
                          16'h0100};
  logic [13:0] fw [4] = '{14'h00D5, 14'h03AA, 14'h1F7F, 14'h2E06};

  itd_core u_itd_core (
    .clk         (clk),
    .rst         (rst),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .busy        (busy)
  );

  always #4 clk = ~clk;

  // length of the latest busy stretch, in clocks
  always @(posedge clk) begin
    run_len <= (busy === 1'b1) ? run_len + 1 : 0;
    if (busy !== 1'b1 && run_len != 0) last_len <= run_len;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("[FAIL] wait_bound exp done got timeout");
    summarize();
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus(input logic is_wr, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    address   <= a;
    writedata <= d;
    write     <= is_wr;
    read      <= ~is_wr;
    // waitrequest and readdata read before this edge updates them
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang();
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] e,
                       input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy === 1'b1 && n < 100);
    if (n >= 100) hang();
    repeat (2) @(posedge clk);
  endtask

  task automatic run(input logic [13:0] w);
    wr(itd_pkg::A_INSTR, {18'h0, w});
    idle();
  endtask

  // class, instruction cycles and indirect flag of the last run
  task automatic stat(input logic [1:0] c, input logic [1:0] n,
                      input logic i);
    rdchk(itd_pkg::A_STATUS, {26'h0, i, n, c, 1'b0}, "status");
    chk("busy_len", {31'h0, last_len >= n * 4 + 1 && last_len <= n * 4 + 4},
        32'h1);
  endtask

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    address   = 6'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0;
    rd        = 32'h0;
    run_len   = 0;
    last_len  = 0;
    error_cnt = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(itd_pkg::A_CTRL, 32'h0, "ctrl_rst");
    rdchk(itd_pkg::A_MASK, 32'h0, "mask_rst");
    rdchk(itd_pkg::A_ACC, 32'h0, "acc_rst");
    rdchk(itd_pkg::A_PTRS, 32'h0, "ptrs_rst");
    rdchk(itd_pkg::A_STATUS, 32'h0, "status_rst");
    wr(6'h3C, 32'hFFFF_FFFF);
    rdchk(6'h3C, 32'h0, "unmapped");
    // bit ops below touch 0x00 and 0x7F; give them known contents
    wr(itd_pkg::A_FDATA, 32'h0);
    wr(itd_pkg::A_FADDR, 32'h7F);
    wr(itd_pkg::A_FDATA, 32'h0);
    foreach (fw[i]) begin
      run(fw[i]);
      rdchk(itd_pkg::A_FIELDS, {18'h0, fw[i][1:0], fw[i][2], fw[i][9:7],
            fw[i][7], fw[i][6:0]}, "fields");
    end
    // byte ops at the top file address, both destinations
    wr(itd_pkg::A_MASK, 32'hFF);
    wr(itd_pkg::A_FADDR, 32'h7F);
    wr(itd_pkg::A_FDATA, 32'h3C);
    run(14'h00FF);
    rdchk(itd_pkg::A_FDATA, 32'hC3, "file_d1");
    rdchk(itd_pkg::A_ACC, 32'h06, "acc_d1");
    rdchk(itd_pkg::A_FADDR, 32'h7F, "faddr");
    run(14'h007F);
    rdchk(itd_pkg::A_ACC, 32'h3C, "acc_d0");
    rdchk(itd_pkg::A_FDATA, 32'hC3, "file_d0");
    stat(2'h0, 2'h1, 1'b0);
    // bit ops on both end bits
    run(14'h13FF);
    rdchk(itd_pkg::A_FDATA, 32'h43, "bit7");
    run(14'h107F);
    rdchk(itd_pkg::A_FDATA, 32'h42, "bit0");
    stat(2'h1, 2'h1, 1'b0);
    // every flow kind; bit 12 is ignored in literal words
    for (int k = 0; k < 4; k++) begin
      wr(itd_pkg::A_CTRL, {28'h0, k[1:0], 2'h0});
      run({1'b1, k[0], 4'h0, 4'h5, k[3:0]});
      rdchk(itd_pkg::A_ACC, {24'h0, 4'h5, k[3:0]}, "lit");
      stat(2'h2, (k == 0) ? 2'h1 : 2'h2, 1'b0);
    end
    // pointer 1 flagged as program memory
    wr(itd_pkg::A_CTRL, 32'h2);
    run(14'h0001);
    stat(2'h0, 2'h2, 1'b1);
    run(14'h0000);
    stat(2'h0, 2'h1, 1'b0);
    run(14'h1001);
    stat(2'h1, 2'h2, 1'b1);
    wr(itd_pkg::A_CTRL, 32'h6);
    run(14'h0001);
    stat(2'h0, 2'h3, 1'b1);
    // pointer moves in every update mode
    wr(itd_pkg::A_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(itd_pkg::A_FADDR, i);
      wr(itd_pkg::A_FDATA, 32'hA0 + i);
    end
    wr(itd_pkg::A_CTRL, 32'h10);
    foreach (pw[i]) begin
      run({6'h20, 5'h0, pw[i]});
      rdchk(itd_pkg::A_ACC, {24'h0, pa[i]}, "ptr_acc");
      rdchk(itd_pkg::A_PTRS, {16'h0, pp[i]}, "ptrs");
    end
    // writes while busy are dropped
    wr(itd_pkg::A_CTRL, 32'h0);
    wr(itd_pkg::A_INSTR, 32'h2011);
    wr(itd_pkg::A_ACC, 32'h55);
    idle();
    rdchk(itd_pkg::A_ACC, 32'h11, "busy_drop");
    summarize();
  end
endmodule
`default_nettype wire
